/* src/ame_core.sv */
// Implementation choices: the register addresses and the Wishbone register port.
`timescale 1ns/1ps
// Function
// - Copy with I=0 defers, address via buffer; I=1 takes PC address.
// - Copy always runs second execute; address from a, cleared middle, field.
// - Second execute of copy suppresses buffer load; buffer written back at TP4.
// - Index-skip addresses low register in field; increments when I=1.
// - Index-skip sets skip flag at TP5 when buffer bits 02-11 are all ones.
// - Point display executes; horizontal from register, vertical from AC, channel at TP5.
// - Busy display pauses timing in time state 5 until free.
// - Display init loads positions, sets active, 25 us, intensify, active clears.
// - Set-field loads buffer at TP4, saves current field; jump transfers buffer.
// - Set-data-field loads data field at fetch TP5.
// - Sample selects channel, returns ten bits; recycles TS5 unless fast.
// - Sample with pause and not fast sets ff_a, loads channel at TP4.
// - Settle 6 us, convert; done clears pause and recycles; AC loaded every TP5.
// - Bits 0-6 zero select operate group; N=0 halts at fetch TP5.
// - N=2 switches mode to native set at TP1.
// - Enable-special loads AC bits 2-6 into flags; bit 7 presets devices.
// - Read-special puts flags in AC, other bits cleared.
// - N=5 moves MQ right one into AC; N=6 clears save-PC flag.
// - N=11 clears AC, link and MQ.
// - N=14 loads relays from AC 6-11; N=15 loads AC 6-11 from relays.
// - N=17 complements the AC at TP5.
module ame_core (
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  input  wire logic        i_wb_cyc,
  input  wire logic        i_wb_stb,
  input  wire logic        i_wb_we,
  input  wire logic [7:0]  i_wb_adr,
  input  wire logic [3:0]  i_wb_sel,
  input  wire logic [31:0] i_wb_dat,
  output logic      [31:0] o_wb_dat,
  output logic             o_wb_ack,
  input  wire logic        i_adc_done,
  input  wire logic [9:0]  i_adc_data,
  output logic      [4:0]  o_adc_chan,
  output logic             o_adc_start,
  output logic      [8:0]  o_disp_x,
  output logic      [8:0]  o_disp_y,
  output logic             o_disp_chan,
  output logic             o_disp_init,
  output logic             o_disp_load,
  output logic             o_disp_int11,
  output logic             o_disp_intensify,
  output logic             o_disp_active,
  output logic      [5:0]  o_relay,
  output logic             o_io_preset
);
  ame_pkg::ame_major_t major_r;
  ame_pkg::ame_ts_t    ts_r;
  logic [11:0] pc_r, ma_r, mb_r, ir_r, ac_r, mq_r;
  logic        link_r, skip_r, run_r, alt_mode_r, save_pc_r;
  logic [4:0]  if_r, field_buffer, save_field_r, data_field_reg, sf_r;
  logic [11:0] mem [0:ame_pkg::MEM_WORDS-1];
  logic [9:0]  mem_adr_r, disp_cnt_r, settle_cnt_r, adc_reg;
  logic        converter_pause_flag, ff_a, time_state5_repeat_ff, settling_r;
  logic        done_s1, done_s2, done_s3;
  logic [9:0]  data_s1, data_s2;
  logic        display_busy;

  wire logic [9:0] mem_idx = {ma_r[11:10], ma_r[7:0]};
  wire logic [11:0] mem_q  = mem[mem_idx];
  wire logic [6:0] opc     = ir_r[11:5];
  wire logic       ind     = ir_r[4];
  wire logic [3:0] n_code  = ir_r[3:0];
  wire logic [11:0] lo_adr = {if_r[1:0], 6'h00, ir_r[3:0]};
  wire logic is_set = (opc == ame_pkg::OP_SET);
  wire logic is_xsk = (opc == ame_pkg::OP_XSK);
  wire logic is_dis = (opc == ame_pkg::OP_DIS);
  wire logic is_sam = (opc == ame_pkg::OP_SAM);
  wire logic is_msc = (opc == ame_pkg::OP_MSC);
  wire logic going  = run_r && alt_mode_r;
  wire logic fetch  = (major_r == ame_pkg::MS_FETCH);
  wire logic exec   = (major_r == ame_pkg::MS_EXEC);
  wire logic exec2  = (major_r == ame_pkg::MS_EXEC2);
  wire logic defer  = (major_r == ame_pkg::MS_DEFER);
  // Display pause holds time state 5 without issuing TP5
  wire logic disp_hold = exec && is_dis && display_busy;
  wire logic tp1 = going && (ts_r == ame_pkg::TS1);
  wire logic tp2 = going && (ts_r == ame_pkg::TS2);
  wire logic tp3 = going && (ts_r == ame_pkg::TS3);
  wire logic tp4 = going && (ts_r == ame_pkg::TS4);
  wire logic tp5 = going && (ts_r == ame_pkg::TS5) && !disp_hold;
  wire logic msc_f5 = tp5 && fetch && is_msc;
  wire logic sam_rec = tp4 && fetch && is_sam && converter_pause_flag
                       && !sf_r[3];
  wire logic recycle = ff_a && converter_pause_flag;
  wire logic bus_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
  wire logic bus_wr  = bus_req && i_wb_we && (i_wb_sel[1:0] == 2'b11);
  wire logic [5:0] ra = i_wb_adr[7:2];

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      major_r <= ame_pkg::MS_FETCH;
      ts_r    <= ame_pkg::TS1;
    end else if (going) begin
      case (ts_r)
        ame_pkg::TS1: ts_r <= ame_pkg::TS2;
        ame_pkg::TS2: ts_r <= ame_pkg::TS3;
        ame_pkg::TS3: ts_r <= ame_pkg::TS4;
        ame_pkg::TS4: ts_r <= ame_pkg::TS5;
        ame_pkg::TS5: begin
          if (tp5 && !recycle) begin
            ts_r <= ame_pkg::TS1;
            case (major_r)
              ame_pkg::MS_FETCH: begin
                if (is_set)
                  major_r <= ind ? ame_pkg::MS_EXEC : ame_pkg::MS_DEFER;
                else if (is_xsk || is_dis || (is_msc && n_code == ame_pkg::N_MODE))
                  major_r <= ame_pkg::MS_EXEC;
              end
              ame_pkg::MS_DEFER: major_r <= ame_pkg::MS_EXEC;
              ame_pkg::MS_EXEC:  major_r <= is_set ? ame_pkg::MS_EXEC2 : ame_pkg::MS_FETCH;
              default:           major_r <= ame_pkg::MS_FETCH;
            endcase
          end
        end
        default: ts_r <= ame_pkg::TS1;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      pc_r   <= 12'h000;
      ma_r   <= 12'h000;
      mb_r   <= 12'h000;
      ir_r   <= 12'h000;
      skip_r <= 1'b0;
    end else begin
      if (tp1 && fetch && skip_r) begin
        pc_r   <= pc_r + 12'h001;
        skip_r <= 1'b0;
      end
      if (tp2 && fetch)
        ma_r <= pc_r;
      if (tp3 && fetch) begin
        ir_r <= mem_q;
        pc_r <= pc_r + 12'h001;
      end
      if (tp1 && defer)
        ma_r <= pc_r;
      if (tp3 && defer) begin
        mb_r <= mem_q;
        pc_r <= pc_r + 12'h001;
      end
      if (tp1 && exec && is_set)
        ma_r <= ind ? pc_r : mb_r;
      if (tp3 && exec && is_set) begin
        mb_r <= mem_q;
        if (ind)
          pc_r <= pc_r + 12'h001;
      end
      if (tp1 && (exec2 || (exec && (is_xsk || is_dis))))
        ma_r <= lo_adr;
      if (tp3 && exec && is_xsk)
        mb_r <= mem_q + {11'h000, ind};
      if (tp3 && exec && is_dis)
        mb_r <= mem_q;
      if (tp5 && exec && is_xsk && (&mb_r[9:0]))
        skip_r <= 1'b1;
      if (bus_wr && ra == ame_pkg::RA_PC && !going)
        pc_r <= i_wb_dat[11:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (going && (ts_r == ame_pkg::TS4) && (exec2 || (exec && is_xsk)))
      mem[mem_idx] <= mb_r;
    else if (bus_wr && ra == ame_pkg::RA_MDAT)
      mem[mem_adr_r] <= i_wb_dat[11:0];
  end

  always_ff @(posedge i_clk) begin
    if (i_reset)
      mem_adr_r <= 10'h000;
    else if (bus_wr && ra == ame_pkg::RA_MADR)
      mem_adr_r <= i_wb_dat[9:0];
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      ac_r   <= 12'h000;
      mq_r   <= 12'h000;
      link_r <= 1'b0;
    end else if (tp5 && fetch && is_sam) begin
      ac_r <= {2'b00, adc_reg};
    end else if (msc_f5) begin
      case (n_code)
        ame_pkg::N_SPEC: if (ind) ac_r <= {2'b00, sf_r[0], sf_r[1], sf_r[2], sf_r[3], sf_r[4],
                                           5'h00};
        ame_pkg::N_QAC:  ac_r <= {1'b0, mq_r[11:1]};
        ame_pkg::N_CLR: begin
          ac_r   <= 12'h000;
          mq_r   <= 12'h000;
          link_r <= 1'b0;
        end
        ame_pkg::N_RTA:  ac_r <= {6'h00, o_relay};
        ame_pkg::N_COM:  ac_r <= ~ac_r;
        default: ;
      endcase
    end else if (bus_wr && !going) begin
      if (ra == ame_pkg::RA_AC) begin
        ac_r   <= i_wb_dat[11:0];
        link_r <= i_wb_dat[12];
      end
      if (ra == ame_pkg::RA_MQ)
        mq_r <= i_wb_dat[11:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      if_r           <= 5'h00;
      field_buffer   <= 5'h00;
      save_field_r   <= 5'h00;
      data_field_reg <= 5'h00;
    end else begin
      if (tp4 && fetch && opc == ame_pkg::OP_LIF) begin
        field_buffer <= ir_r[4:0];
        save_field_r <= if_r;
      end
      if (tp5 && fetch && opc == ame_pkg::OP_LDF)
        data_field_reg <= ir_r[4:0];
      if (bus_wr && ra == ame_pkg::RA_CTRL && i_wb_dat[ame_pkg::CB_JUMP])
        if_r <= field_buffer;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      run_r      <= 1'b0;
      alt_mode_r <= 1'b1;
      save_pc_r  <= 1'b0;
    end else if (msc_f5 && n_code == ame_pkg::N_HALT) begin
      run_r <= 1'b0;
    end else if (tp1 && exec && is_msc && n_code == ame_pkg::N_MODE) begin
      alt_mode_r <= 1'b0;
    end else if (msc_f5 && n_code == ame_pkg::N_DJR) begin
      save_pc_r <= 1'b0;
    end else if (bus_wr && ra == ame_pkg::RA_CTRL) begin
      run_r <= i_wb_dat[ame_pkg::CB_RUN];
      if (i_wb_dat[ame_pkg::CB_ALT])
        alt_mode_r <= 1'b1;
      if (i_wb_dat[3])
        save_pc_r <= 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      sf_r        <= 5'h00;
      o_io_preset <= 1'b0;
      o_relay     <= 6'h00;
    end else begin
      o_io_preset <= 1'b0;
      if (msc_f5 && n_code == ame_pkg::N_SPEC && !ind) begin
        // Flag 0 is the trap enable, taken from the leftmost special bit
        sf_r        <= {ac_r[5], ac_r[6], ac_r[7], ac_r[8], ac_r[9]};
        o_io_preset <= ac_r[4];
      end
      if (msc_f5 && n_code == ame_pkg::N_ATR)
        o_relay <= ac_r[5:0];
    end
  end

  // Converter result crosses in by two flops; data sampled only after done settles
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
      done_s3 <= 1'b0;
      data_s1 <= 10'h000;
      data_s2 <= 10'h000;
      adc_reg <= 10'h000;
    end else begin
      done_s1 <= i_adc_done;
      done_s2 <= done_s1;
      done_s3 <= done_s2;
      data_s1 <= i_adc_data;
      data_s2 <= data_s1;
      if (done_s2 && !done_s3)
        adc_reg <= data_s2;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      converter_pause_flag  <= 1'b0;
      ff_a                  <= 1'b0;
      time_state5_repeat_ff <= 1'b0;
      o_adc_chan            <= 5'h00;
      o_adc_start           <= 1'b0;
      settling_r            <= 1'b0;
      settle_cnt_r          <= 10'h000;
    end else begin
      o_adc_start <= 1'b0;
      if (tp3 && fetch && mem_q[11:5] == ame_pkg::OP_SAM)
        converter_pause_flag <= 1'b1;
      if (sam_rec) begin
        ff_a         <= 1'b1;
        o_adc_chan   <= ir_r[4:0];
        settling_r   <= 1'b1;
        settle_cnt_r <= ame_pkg::SETTLE_LOAD;
      end
      if (settling_r) begin
        settle_cnt_r <= settle_cnt_r - 10'h001;
        if (settle_cnt_r == 10'h000) begin
          settling_r  <= 1'b0;
          o_adc_start <= 1'b1;
        end
      end
      if (done_s2 && !done_s3)
        converter_pause_flag <= 1'b0;
      if (tp5 && fetch && is_sam) begin
        ff_a                  <= recycle;
        time_state5_repeat_ff <= recycle;
      end
    end
  end

  assign display_busy = o_disp_active || o_disp_init || o_disp_load;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_disp_x         <= 9'h000;
      o_disp_y         <= 9'h000;
      o_disp_chan      <= 1'b0;
      o_disp_init      <= 1'b0;
      o_disp_load      <= 1'b0;
      o_disp_int11     <= 1'b0;
      o_disp_intensify <= 1'b0;
      o_disp_active    <= 1'b0;
      disp_cnt_r       <= 10'h000;
    end else begin
      o_disp_init      <= 1'b0;
      o_disp_load      <= 1'b0;
      o_disp_intensify <= 1'b0;
      if (tp5 && exec && is_dis) begin
        o_disp_x    <= mb_r[8:0];
        o_disp_y    <= ac_r[8:0];
        o_disp_chan <= mb_r[11];
        o_disp_init <= 1'b1;
      end
      if (o_disp_init) begin
        o_disp_load   <= 1'b1;
        o_disp_int11  <= 1'b1;
        o_disp_active <= 1'b1;
        disp_cnt_r    <= ame_pkg::DISP_LOAD;
      end else if (o_disp_active) begin
        disp_cnt_r <= disp_cnt_r - 10'h001;
        if (disp_cnt_r == 10'h000) begin
          o_disp_intensify <= 1'b1;
          o_disp_active    <= 1'b0;
          o_disp_int11     <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0000_0000;
    end else begin
      o_wb_ack <= bus_req;
      o_wb_dat <= 32'h0000_0000;
      if (bus_req && !i_wb_we) begin
        case (ra)
          ame_pkg::RA_CTRL:  o_wb_dat <= {23'h0, ts_r, major_r, skip_r, save_pc_r,
                                          alt_mode_r, run_r};
          ame_pkg::RA_PC:    o_wb_dat <= {20'h0, pc_r};
          ame_pkg::RA_AC:    o_wb_dat <= {19'h0, link_r, ac_r};
          ame_pkg::RA_MQ:    o_wb_dat <= {20'h0, mq_r};
          ame_pkg::RA_FIELD: o_wb_dat <= {12'h0, data_field_reg, save_field_r,
                                          field_buffer, if_r};
          ame_pkg::RA_MADR:  o_wb_dat <= {22'h0, mem_adr_r};
          ame_pkg::RA_MDAT:  o_wb_dat <= {20'h0, mem[mem_adr_r]};
          ame_pkg::RA_STAT:  o_wb_dat <= {18'h0, time_state5_repeat_ff, ff_a,
                                          converter_pause_flag, o_relay, sf_r};
          default:           o_wb_dat <= 32'h0000_0000;
        endcase
      end
    end
  end

  localparam int DLY_DISP = 500;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);

  AST_HALT: assert property (msc_f5 && n_code == ame_pkg::N_HALT |=> !run_r)
    else $error("halt did not clear run");
  AST_COMP: assert property (msc_f5 && n_code == ame_pkg::N_COM |=> ac_r == ~$past(ac_r))
    else $error("complement wrong");
  AST_LDF: assert property (tp5 && fetch && opc == ame_pkg::OP_LDF
                            |=> data_field_reg == $past(ir_r[4:0]))
    else $error("data field not loaded");
  AST_DISP_WAIT: assert property (going && ts_r == ame_pkg::TS5 && disp_hold
                                  |=> ts_r == ame_pkg::TS5 && !o_disp_init)
    else $error("timing left TS5 while display busy");
  AST_DISP_TIME: assert property ($rose(o_disp_active)
                                  |-> ##[DLY_DISP:DLY_DISP] o_disp_intensify)
    else $error("intensify not after display delay");
  AST_EXEC2: assert property (tp5 && exec && is_set && !recycle
                              |=> major_r == ame_pkg::MS_EXEC2)
    else $error("copy skipped second execute");
  AST_SAM_REC: assert property (sam_rec |=> ff_a && o_adc_chan == $past(ir_r[4:0]))
    else $error("sample recycle setup wrong");
  AST_XSK_SKIP: assert property (tp5 && exec && is_xsk && (&mb_r[9:0]) |=> skip_r)
    else $error("index skip not set");
  AST_MB_HOLD: assert property (tp3 && exec2 |=> $stable(mb_r))
    else $error("buffer loaded in second execute");
endmodule

/* src/ame_pkg.sv */
package ame_pkg;
  // Major states and time states
  typedef enum logic [1:0] {MS_FETCH, MS_DEFER, MS_EXEC, MS_EXEC2} ame_major_t;
  typedef enum logic [2:0] {TS1, TS2, TS3, TS4, TS5} ame_ts_t;

  // Opcode classes on instruction bits 0-6 (vector bits 11:5)
  localparam logic [6:0] OP_MSC  = 7'h00;
  localparam logic [6:0] OP_SET  = 7'h01;
  localparam logic [6:0] OP_SAM  = 7'h02;
  localparam logic [6:0] OP_DIS  = 7'h03;
  localparam logic [6:0] OP_XSK  = 7'h04;
  localparam logic [6:0] OP_LIF  = 7'h0c;
  localparam logic [6:0] OP_LDF  = 7'h0d;

  // Miscellaneous operate codes N
  localparam logic [3:0] N_HALT  = 4'h0;
  localparam logic [3:0] N_MODE  = 4'h2;
  localparam logic [3:0] N_SPEC  = 4'h4;
  localparam logic [3:0] N_QAC   = 4'h5;
  localparam logic [3:0] N_DJR   = 4'h6;
  localparam logic [3:0] N_CLR   = 4'h9;
  localparam logic [3:0] N_ATR   = 4'hc;
  localparam logic [3:0] N_RTA   = 4'hd;
  localparam logic [3:0] N_COM   = 4'hf;

  // Register word addresses (byte address bits 7:2)
  localparam logic [5:0] RA_CTRL   = 6'h00;
  localparam logic [5:0] RA_PC     = 6'h01;
  localparam logic [5:0] RA_AC     = 6'h02;
  localparam logic [5:0] RA_MQ     = 6'h03;
  localparam logic [5:0] RA_FIELD  = 6'h04;
  localparam logic [5:0] RA_MADR   = 6'h05;
  localparam logic [5:0] RA_MDAT   = 6'h06;
  localparam logic [5:0] RA_STAT   = 6'h07;

  // CTRL write bits
  localparam int CB_RUN  = 0;
  localparam int CB_JUMP = 1;
  localparam int CB_ALT  = 2;

  // Timing
  localparam int CLK_NS       = 50;
  localparam int DISP_DLY_NS  = 25000;
  localparam int SETTLE_NS    = 6000;
  localparam int DISP_CYC     = (DISP_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETTLE_CYC   = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [9:0] DISP_LOAD   = 10'(DISP_CYC - 1);
  localparam logic [9:0] SETTLE_LOAD = 10'(SETTLE_CYC - 1);
  localparam int MEM_WORDS = 1024;
endpackage

/* bench/ame_adc_model.sv */
`timescale 1ns/1ps
module ame_adc_model (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic       i_slow,
  input  wire logic [9:0] i_val,
  output logic            o_done,
  output logic      [9:0] o_data
);
  int cnt = -1;

  initial begin
    o_done = 1'b0;
    o_data = 10'h000;
  end

  // conversion time and result
  // Result holds only while done is up; otherwise the lines toggle so stale
  // data is never mistaken for a valid sample.
  always @(posedge i_clk) begin
    if (i_start === 1'b1) begin
      cnt <= i_slow ? 300 : 5;
    end else if (cnt >= 0) begin
      cnt <= cnt - 1;
    end
    o_done <= (cnt >= 0 && cnt < 4);
    o_data <= (cnt >= 0 && cnt < 4) ? i_val : ~o_data;
  end
endmodule

/* bench/ame_core_tb_top.sv */
`timescale 1ns/1ps
module ame_core_tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd_q;
  logic [31:0] q;
  logic        ack;
  logic        done;
  logic [9:0]  adata;
  logic [9:0]  aval = 10'h000;
  logic        slow = 1'b0;
  logic [4:0]  chan;
  logic [4:0]  chan_q = 5'h00;
  logic        start;
  logic [8:0]  dx;
  logic [8:0]  dy;
  logic        dint11;
  logic        dinten;
  logic        dact;
  logic [5:0]  relay;
  logic        preset;
  int          n_errors = 0;
  int          compares = 0;
  int          n_inten = 0;
  int          n_pre = 0;
  int          n_start = 0;
  int          act_cnt = 0;
  int          act_len = 0;
  int          since = 0;
  int          gap = 0;
  logic [11:0] sx [8] = '{12'o0065, 12'o4321, 12'o0046, 12'o0005,
                          12'o0226, 12'o0227, 12'o0017, 12'o0000};

  always #25 clk = ~clk;

  ame_core dut_u (
    .i_clk            (clk),
    .i_reset          (rst),
    .i_wb_cyc         (cyc),
    .i_wb_stb         (stb),
    .i_wb_we          (we),
    .i_wb_adr         (adr),
    .i_wb_sel         (sel),
    .i_wb_dat         (wd),
    .o_wb_dat         (rd_q),
    .o_wb_ack         (ack),
    .i_adc_done       (done),
    .i_adc_data       (adata),
    .o_adc_chan       (chan),
    .o_adc_start      (start),
    .o_disp_x         (dx),
    .o_disp_y         (dy),
    .o_disp_chan      (),
    .o_disp_init      (),
    .o_disp_load      (),
    .o_disp_int11     (dint11),
    .o_disp_intensify (dinten),
    .o_disp_active    (dact),
    .o_relay          (relay),
    .o_io_preset      (preset)
  );

  ame_adc_model adc_u (
    .i_clk   (clk),
    .i_start (start),
    .i_slow  (slow),
    .i_val   (aval),
    .o_done  (done),
    .o_data  (adata)
  );

  always @(posedge clk) begin
    chan_q <= chan;
    since <= (chan !== chan_q) ? 0 : since + 1;
    if (start === 1'b1) begin
      gap <= since;
      n_start <= n_start + 1;
    end
    if (dinten === 1'b1) n_inten <= n_inten + 1;
    if (preset === 1'b1) n_pre <= n_pre + 1;
    act_cnt <= (dact === 1'b1) ? act_cnt + 1 : 0;
    if (dact !== 1'b1 && act_cnt != 0) act_len <= act_cnt;
  end

  task automatic give_verdict();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int t;
    t = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {a, 2'b00};
    wd <= d;
    sel <= s;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && t < 50);
    if (ack !== 1'b1) begin
      n_errors++;
      give_verdict();
    end
    q = rd_q;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'hf);
  endtask

  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic mem(input logic [9:0] a, input logic [11:0] d);
    wr(ame_pkg::RA_MADR, 32'(a));
    wr(ame_pkg::RA_MDAT, 32'(d));
  endtask

  task automatic mr(input logic [9:0] a);
    wr(ame_pkg::RA_MADR, 32'(a));
    rd(ame_pkg::RA_MDAT);
  endtask

  task automatic until_ctrl(input int b);
    int n;
    n = 0;
    do begin
      rd(ame_pkg::RA_CTRL);
      n++;
    end while (q[b] !== 1'b0 && n < 3000);
    if (q[b] !== 1'b0) begin
      n_errors++;
      give_verdict();
    end
  endtask

  task automatic go();
    wr(ame_pkg::RA_PC, 32'o20);
    wr(ame_pkg::RA_CTRL, 32'h5);
    until_ctrl(0);
    chk("halt", 32'(q[0]), 32'h0);
  endtask

  task automatic prog3(input logic [11:0] w0, input logic [11:0] w1,
                       input logic [11:0] w2, input logic [31:0] ac,
                       input logic [31:0] mq);
    mem(10'o20, w0);
    mem(10'o21, w1);
    mem(10'o22, w2);
    wr(ame_pkg::RA_AC, ac);
    wr(ame_pkg::RA_MQ, mq);
    go();
  endtask

  initial begin
    #3000000;
    n_errors++;
    give_verdict();
  end

  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    wr(ame_pkg::RA_AC, 32'o1234);
    bus(1'b1, ame_pkg::RA_AC, 32'h0, 4'hc);
    rd(ame_pkg::RA_AC);
    chk("ac_sel", q, 32'o1234);
    rd(6'h3f);
    chk("unmapped", q, 32'h0);
    prog3(12'o0017, 0, 0, 32'o1234, 0);
    rd(ame_pkg::RA_AC);
    chk("com", q, 32'o6543);
    prog3(12'o0005, 0, 0, 0, 32'o2525);
    rd(ame_pkg::RA_AC);
    chk("qac", q, 32'o1252);
    prog3(12'o0011, 0, 0, 32'o11234, 32'o7777);
    rd(ame_pkg::RA_AC);
    chk("clr_ac", q, 32'h0);
    rd(ame_pkg::RA_MQ);
    chk("clr_mq", q, 32'h0);
    prog3(12'o0014, 12'o0015, 0, 32'o7752, 0);
    chk("relay", 32'(relay), 32'o52);
    rd(ame_pkg::RA_AC);
    chk("rta", q, 32'o0052);
    prog3(12'o0004, 12'o0024, 0, 32'o1360, 0);
    chk("preset", n_pre, 32'h1);
    rd(ame_pkg::RA_STAT);
    chk("esf", 32'(q[4:0]), 32'h1d);
    rd(ame_pkg::RA_AC);
    chk("sfa", q, 32'o1340);
    // Word after the stop must never execute
    prog3(12'o0004, 12'o0000, 12'o0017, 0, 0);
    rd(ame_pkg::RA_AC);
    chk("stop", q, 32'h0);
    rd(ame_pkg::RA_STAT);
    chk("esf_clr", 32'(q[4:0]), 32'h0);
    foreach (sx[i]) mem(10'o20 + 10'(i), sx[i]);
    mem(10'o7, 12'o1776);
    go();
    mr(10'o5);
    chk("set_lit", q, 32'o4321);
    mr(10'o6);
    chk("set_ind_xsk", q, 32'o4322);
    mr(10'o7);
    chk("xsk_inc", q, 32'o1777);
    rd(ame_pkg::RA_AC);
    chk("xsk_skip", q, 32'h0);
    wr(ame_pkg::RA_CTRL, 32'h8);
    rd(ame_pkg::RA_CTRL);
    chk("djr_set", 32'(q[2]), 32'h1);
    prog3(12'o0006, 0, 0, 0, 0);
    rd(ame_pkg::RA_CTRL);
    chk("djr", 32'(q[2]), 32'h0);
    mem(10'o3, 12'o0525);
    mem(10'o4, 12'o0123);
    prog3(12'o0143, 12'o0144, 0, 32'o0377, 0);
    for (int i = 0; i < 2000 && n_inten < 2; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("intens", n_inten, 32'h2);
    chk("active", act_len, ame_pkg::DISP_CYC);
    chk("int11", 32'(dint11), 32'h0);
    chk("dx", 32'(dx), 32'o123);
    chk("dy", 32'(dy), 32'o377);
    aval <= 10'h2a5;
    prog3(12'o0113, 0, 0, 0, 0);
    rd(ame_pkg::RA_AC);
    chk("sam", 32'(q[9:0]), 32'h2a5);
    chk("chan", 32'(chan), 32'o13);
    chk("settle", 32'(gap >= ame_pkg::SETTLE_CYC - 2 && gap <= ame_pkg::SETTLE_CYC + 2),
        32'h1);
    slow <= 1'b1;
    aval <= 10'h15a;
    prog3(12'o0127, 0, 0, 0, 0);
    rd(ame_pkg::RA_AC);
    chk("sam_slow", 32'(q[9:0]), 32'h15a);
    chk("starts", n_start, 32'h2);
    rd(ame_pkg::RA_STAT);
    chk("recycle", 32'(q[13:11]), 32'h0);
    prog3(12'o0665, 12'o0613, 0, 0, 0);
    rd(ame_pkg::RA_FIELD);
    chk("fields", q, 32'h000a8160);
    wr(ame_pkg::RA_CTRL, 32'h2);
    rd(ame_pkg::RA_FIELD);
    chk("jump_if", 32'(q[4:0]), 32'o13);
    mem(10'o20, 12'o0002);
    wr(ame_pkg::RA_PC, 32'o20);
    wr(ame_pkg::RA_CTRL, 32'h5);
    until_ctrl(1);
    chk("mode", 32'(q[1]), 32'h0);
    give_verdict();
  end
endmodule
